/* File: hw/bpe_defs.vh */
`ifndef BPE_DEFS_VH
`define BPE_DEFS_VH

// Bus geometry
`define BPE_ADDR_W        8
`define BPE_DATA_W        32

// Register byte offsets
`define BPE_OFS_INTR      8'h00
`define BPE_OFS_MASK      8'h04
`define BPE_OFS_MASKED    8'h08
`define BPE_OFS_CTL       8'h0C
`define BPE_OFS_STATUS    8'h10
`define BPE_OFS_BREG      8'h40
`define BPE_BREG_COUNT    16
`define BPE_BREG_AW       4

// Interrupt bit positions
`define BPE_IRQ_FIRST_ALARM_IRQ    0
`define BPE_IRQ_SECOND_ALARM_IRQ    1
`define BPE_IRQ_ROLL      2
`define BPE_IRQ_W         3

// Regulator control field positions
`define BPE_CTL_KEY_LSB   0
`define BPE_CTL_KEY_MSB   7
`define BPE_CTL_POL       8
`define BPE_CTL_OUTEN     9
`define BPE_CTL_FORCE     10
`define BPE_CTL_EN        11

// Status bit positions
`define BPE_ST_OUT        0
`define BPE_ST_OE         1
`define BPE_ST_WAKEIN     2

// Reset values and constants
`define BPE_RST_MASK      3'h0
`define BPE_RST_KEY       8'h00
`define BPE_RST_POL       1'b1
`define BPE_RST_OUTEN     1'b1
`define BPE_RST_FORCE     1'b1
`define BPE_RST_EN        1'b1
`define BPE_UNLOCK_KEY    8'h3A
`define BPE_YEAR_LAST     8'h99
`define BPE_YEAR_FIRST    8'h00

`endif

/* File: hw/bpe_retention_mem.v */
`timescale 1ns/10ps
`include "bpe_defs.vh"

module bpe_retention_mem #(
  parameter DATA_W = `BPE_DATA_W,
  parameter DEPTH  = `BPE_BREG_COUNT,
  parameter AW     = `BPE_BREG_AW
) (
  input  wire              clk,     // Backup clock
  input  wire              rst_n,   // Sync reset, read port only
  input  wire              ce,      // Clock enable
  input  wire              wrEn,    // Write strobe
  input  wire [AW-1:0]     wrAddr,  // Write word index
  input  wire [DATA_W-1:0] wrData,  // Write data
  input  wire [3:0]        wrBe,    // Byte enables
  input  wire              rdEn,    // Read strobe
  input  wire [AW-1:0]     rdAddr,  // Read word index
  output reg  [DATA_W-1:0] rdData   // Registered read data
);

  // Contents are never reset so they survive any reset of the logic
  reg [DATA_W-1:0] mem [0:DEPTH-1];
  integer b;

  always @(posedge clk) begin
    if (ce && wrEn) begin
      for (b = 0; b < 4; b = b + 1) begin
        if (wrBe[b]) begin
          mem[wrAddr][b*8 +: 8] <= wrData[b*8 +: 8];
        end
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      rdData <= {DATA_W{1'b0}};
    end else if (ce && rdEn) begin
      rdData <= mem[rdAddr];
    end
  end

endmodule

/* File: hw/bpe_ctrl.v */
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
`include "bpe_defs.vh"


module bpe_ctrl #(
  parameter ADDR_W = `BPE_ADDR_W,
  parameter DATA_W = `BPE_DATA_W,
  parameter BREG_N = `BPE_BREG_COUNT,
  parameter BREG_AW = `BPE_BREG_AW
) (
  input  wire              clk,             // Backup-domain clock
  input  wire              rst_n,           // Backup-domain reset
  input  wire              ce,              // Clock enable
  input  wire [ADDR_W-1:0] address,         // Avalon byte address
  input  wire              read,            // Avalon read
  input  wire              write,           // Avalon write
  input  wire [DATA_W-1:0] writedata,       // Avalon write data
  input  wire [3:0]        byteenable,      // Avalon byte enables
  output wire [DATA_W-1:0] readdata,        // Avalon read data
  output wire              waitrequest,     // Avalon wait
  input  wire              firstAlarmIrq,   // First alarm event pulse
  input  wire              secondAlarmIrq,  // Second alarm event pulse
  input  wire [7:0]        yearBcd,         // Calendar year, BCD
  input  wire              regulatorWakeInput,  // Wake input pin
  output reg               regulatorWakeOutput, // Power IC enable
  output reg               regulatorWakeOe,     // Pin output enable
  output reg               irq              // Interrupt level
);

  function [31:0] mergeBytes;
    input [31:0] oldWord;
    input [31:0] newWord;
    input [3:0]  be;
    integer i;
    begin
      mergeBytes = oldWord;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          mergeBytes[i*8 +: 8] = newWord[i*8 +: 8];
        end
      end
    end
  endfunction

  function isKey;
    input [7:0] key;
    begin
      isKey = (key == `BPE_UNLOCK_KEY);
    end
  endfunction

  // One-hot register select, shared by the read mux and the write strobes
  function [4:0] regSel;
    input [ADDR_W-1:0] addr;
    begin
      case (addr)
        `BPE_OFS_INTR:   regSel = 5'h01;
        `BPE_OFS_MASK:   regSel = 5'h02;
        `BPE_OFS_MASKED: regSel = 5'h04;
        `BPE_OFS_CTL:    regSel = 5'h08;
        `BPE_OFS_STATUS: regSel = 5'h10;
        default:         regSel = 5'h00;
      endcase
    end
  endfunction

  // Retention window; the upper bound is the last word, so it cannot wrap
  function inBreg;
    input [ADDR_W-1:0] addr;
    begin
      inBreg = (addr >= `BPE_OFS_BREG) &&
               (addr <= `BPE_OFS_BREG + 8'h3C);
    end
  endfunction

  // Bus handshake states; every access sees exactly one wait cycle
  localparam [0:0] BUS_IDLE   = 1'b0;
  localparam [0:0] BUS_ANSWER = 1'b1;

  // Bus handshake state
  reg [0:0]          busState;
  reg [0:0]          next_busState;
  reg [DATA_W-1:0]   regRdata;
  reg                rdFromMem;

  // Register state
  reg [`BPE_IRQ_W-1:0] intReq;
  reg [`BPE_IRQ_W-1:0] intMask;
  reg [7:0]            unlockKey;
  reg                  wakePolarity;
  reg                  pinOutEn;
  reg                  forceOn;
  reg                  enableBit;
  reg [7:0]            yearPrev;
  reg                  yearSeen;

  // Next values
  reg [`BPE_IRQ_W-1:0] next_intReq;
  reg [`BPE_IRQ_W-1:0] next_intMask;
  reg [7:0]            next_unlockKey;
  reg                  next_wakePolarity;
  reg                  next_pinOutEn;
  reg                  next_forceOn;
  reg                  next_enableBit;

  wire                 request;
  wire                 ack;
  wire                 take;
  wire                 wrCommit;
  wire                 isBreg;
  wire [BREG_AW-1:0]   bregIdx;
  wire [DATA_W-1:0]    memRdata;
  wire [`BPE_IRQ_W-1:0] evtVec;
  wire [`BPE_IRQ_W-1:0] maskedReq;
  wire                 rollEvt;
  wire                 wakeEvt;
  wire                 keyOk;
  wire [31:0]          ctlWord;
  wire [31:0]          ctlNew;
  wire [31:0]          maskNew;
  wire [31:0]          clrWord;
  wire                 wrIntr;
  wire                 wrMask;
  wire                 wrCtl;
  wire [2:0]           statusWord;
  wire [4:0]           sel;

  // One wait cycle per access; the answer stands at the second edge
  assign request     = read | write;
  assign take        = request & ~ack;
  assign wrCommit    = ack & write;
  assign waitrequest = request & ~ack;
  assign readdata    = rdFromMem ? memRdata : regRdata;

  assign isBreg  = inBreg(address);
  assign bregIdx = address[BREG_AW+1:2];
  assign sel     = regSel(address);

  assign wrIntr = wrCommit && sel[0];
  assign wrMask = wrCommit && sel[1];
  assign wrCtl  = wrCommit && sel[3];

  // Idle takes a request; answer lowers waitrequest for one cycle
  always @* begin
    next_busState = busState;
    case (busState)
      BUS_IDLE: begin
        if (request) begin
          next_busState = BUS_ANSWER;
        end
      end
      BUS_ANSWER: begin
        next_busState = BUS_IDLE;
      end
      default: begin
        next_busState = BUS_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      busState <= BUS_IDLE;
    end else if (ce) begin
      busState <= next_busState;
    end
  end

  assign ack = (busState == BUS_ANSWER);

  // Read data are latched in the wait cycle so they stand at the answer edge
  always @(posedge clk) begin
    if (!rst_n) begin
      regRdata  <= {DATA_W{1'b0}};
      rdFromMem <= 1'b0;
    end else if (ce && take && read) begin
      rdFromMem <= isBreg;
      case (sel)
        5'h01:   regRdata <= {29'h0, intReq};
        5'h02:   regRdata <= {29'h0, intMask};
        5'h04:   regRdata <= {29'h0, maskedReq};
        5'h08:   regRdata <= ctlWord;
        5'h10:   regRdata <= {29'h0, statusWord};
        default: regRdata <= {DATA_W{1'b0}};
      endcase
    end
  end

  // Retention words have no reset; they outlive the control logic
  bpe_retention_mem #(
    .DATA_W (DATA_W),
    .DEPTH  (BREG_N),
    .AW     (BREG_AW)
  ) uRetention (
    .clk    (clk),
    .rst_n  (rst_n),
    .ce     (ce),
    .wrEn   (wrCommit & isBreg),
    .wrAddr (bregIdx),
    .wrData (writedata),
    .wrBe   (byteenable),
    .rdEn   (take & read & isBreg),
    .rdAddr (bregIdx),
    .rdData (memRdata)
  );

  // Year rollover watch; the first sample only primes the history
  always @(posedge clk) begin
    if (!rst_n) begin
      yearPrev <= 8'h00;
      yearSeen <= 1'b0;
    end else if (ce) begin
      yearPrev <= yearBcd;
      yearSeen <= 1'b1;
    end
  end

  assign rollEvt = yearSeen && (yearPrev == `BPE_YEAR_LAST) &&
                   (yearBcd == `BPE_YEAR_FIRST);

  assign evtVec = {rollEvt, secondAlarmIrq, firstAlarmIrq};
  assign maskedReq = intReq & intMask;

  // Byte enables decide which lanes of a register a write may touch
  assign maskNew = mergeBytes({29'h0, intMask}, writedata, byteenable);
  assign clrWord = mergeBytes(32'h0, writedata, byteenable);

  always @* begin
    next_intMask = intMask;
    if (wrMask) begin
      next_intMask = maskNew[`BPE_IRQ_W-1:0];
    end
  end

  // Write one to clear; a new event in the same cycle keeps its bit
  always @* begin
    next_intReq = intReq;
    if (wrIntr) begin
      next_intReq = intReq & ~clrWord[`BPE_IRQ_W-1:0];
    end
    next_intReq = next_intReq | evtVec;
  end

  // Wake sources for the regulator
  // The wake input is a level and keeps setting the enable while high, but only while the polarity bit is set
  assign wakeEvt = (|(evtVec & intMask)) |
                   (regulatorWakeInput & wakePolarity);

  assign keyOk = isKey(unlockKey);

  assign ctlWord = {20'h0, enableBit, forceOn, pinOutEn,
                    wakePolarity, unlockKey};
  assign ctlNew  = mergeBytes(ctlWord, writedata, byteenable);

  always @* begin
    next_unlockKey    = unlockKey;
    next_wakePolarity = wakePolarity;
    next_pinOutEn     = pinOutEn;
    next_forceOn      = forceOn;
    next_enableBit    = enableBit;
    if (wrCtl) begin
      next_unlockKey    = ctlNew[`BPE_CTL_KEY_MSB:`BPE_CTL_KEY_LSB];
      next_wakePolarity = ctlNew[`BPE_CTL_POL];
      next_pinOutEn     = ctlNew[`BPE_CTL_OUTEN];
      // Key checked is the one already stored, not the one being written
      if (keyOk) begin
        next_enableBit = ctlNew[`BPE_CTL_EN];
      end
      // Setting force-on needs no key, so a stray write can only turn it on
      if (ctlNew[`BPE_CTL_FORCE]) begin
        next_forceOn = 1'b1;
      end else if (keyOk) begin
        next_forceOn = 1'b0;
      end
    end
    if (wakeEvt) begin
      next_enableBit = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      intReq  <= {`BPE_IRQ_W{1'b0}};
      intMask <= `BPE_RST_MASK;
      irq     <= 1'b0;
    end else if (ce) begin
      intReq  <= next_intReq;
      intMask <= next_intMask;
      irq     <= |(next_intReq & next_intMask);
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      unlockKey    <= `BPE_RST_KEY;
      wakePolarity <= `BPE_RST_POL;
      pinOutEn     <= `BPE_RST_OUTEN;
      forceOn      <= `BPE_RST_FORCE;
      enableBit    <= `BPE_RST_EN;
    end else if (ce) begin
      unlockKey    <= next_unlockKey;
      wakePolarity <= next_wakePolarity;
      pinOutEn     <= next_pinOutEn;
      forceOn      <= next_forceOn;
      enableBit    <= next_enableBit;
    end
  end

  // Pin drivers; reset stands for loss of backup power
  always @(posedge clk) begin
    if (!rst_n) begin
      regulatorWakeOutput <= 1'b1;
      regulatorWakeOe     <= 1'b1;
    end else if (ce) begin
      regulatorWakeOutput <= next_forceOn | next_enableBit;
      regulatorWakeOe     <= next_forceOn | next_pinOutEn |
                             ~isKey(next_unlockKey);
    end
  end

  assign statusWord = {regulatorWakeInput, regulatorWakeOe,
                       regulatorWakeOutput};

endmodule

/* File: testbench/bpe_ctrl_properties.sv */
`timescale 1ns/10ps
`include "bpe_defs.vh"
module bpe_ctrl_properties (
  input wire logic        clk,                 // Clock
  input wire logic        rst_n,               // Reset
  input wire logic [7:0]  address,             // Address
  input wire logic        read,                // Read
  input wire logic        write,               // Write
  input wire logic [31:0] readdata,            // Read data
  input wire logic        waitrequest,         // Wait
  input wire logic        firstAlarmIrq,       // Event
  input wire logic        secondAlarmIrq,      // Event
  input wire logic [7:0]  yearBcd,             // Year
  input wire logic        regulatorWakeInput,  // Wake pin
  input wire logic        regulatorWakeOutput, // Enable out
  input wire logic        regulatorWakeOe,     // Pin drive
  input wire logic        irq                  // Interrupt
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] wHist = 3'h0;
  logic [7:0] yPrev = 8'h00;
  logic       evSeen = 1'b0;
  // Register writes reach the pins late, so keep three cycles of history
  always @(posedge clk) begin
    wHist <= {wHist[1:0], write};
    yPrev <= yearBcd;
    evSeen <= firstAlarmIrq | secondAlarmIrq | regulatorWakeInput |
              (yPrev == 8'h99 && yearBcd == 8'h00);
  end
  property p_wait;
    (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("wait too long");
  property p_wake;
    regulatorWakeInput |-> ##[1:2] regulatorWakeOutput;
  endproperty
  a_wake: assert property (p_wake) else $error("wake ignored");
  property p_out_hold;
    $changed(regulatorWakeOutput) |-> (|wHist) || evSeen;
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("out moved");
  property p_oe_hold;
    $changed(regulatorWakeOe) |-> |wHist;
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("oe moved");
  property p_irq_hold;
    $changed(irq) |-> (|wHist) || evSeen;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq moved");
  property p_irq_wake;
    $rose(irq) && !(|wHist) |-> ##[0:1] regulatorWakeOutput;
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("no wake");
  property p_status;
    read && !waitrequest && address == `BPE_OFS_STATUS |->
      readdata[1:0] == {$past(regulatorWakeOe), $past(regulatorWakeOutput)};
  endproperty
  a_status: assert property (p_status) else $error("bad status");
  property p_rst;
    $rose(rst_n) |-> regulatorWakeOutput && regulatorWakeOe && !irq;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset");
  c_off: cover property (!regulatorWakeOutput);
  c_hiz: cover property (!regulatorWakeOe);
  c_irq: cover property ($rose(irq));
endmodule

bind bpe_ctrl bpe_ctrl_properties u_props (.clk, .rst_n, .address, .read,
  .write, .readdata, .waitrequest, .firstAlarmIrq, .secondAlarmIrq,
  .yearBcd, .regulatorWakeInput, .regulatorWakeOutput, .regulatorWakeOe,
  .irq);

/* File: testbench/bpe_pmic_model.sv */
`timescale 1ns/10ps
module bpe_pmic_model #(
  parameter int OFF_DELAY = 6
) (
  input  wire logic clk,      // Clock
  input  wire logic enPin,    // Enable from block
  input  wire logic oe,       // Block drives pin
  output logic      pinLevel, // Resolved pin
  output logic      supplyOn  // Main rail present
);
  logic lastDrv = 1'b1;
  int   lowCnt = 0;
  // Released pin has no pull; model it as the inverse of the last drive
  assign pinLevel = oe ? enPin : ~lastDrv;
  always @(posedge clk) begin
    if (oe) lastDrv <= enPin;
    if (pinLevel) begin
      lowCnt <= 0;
      supplyOn <= 1'b1;
    end else if (lowCnt < OFF_DELAY) begin
      lowCnt <= lowCnt + 1;
    end else begin
      supplyOn <= 1'b0;
    end
  end
endmodule

/* File: testbench/tb_backup_power_enable_ctrl.sv */
`timescale 1ns/10ps
`include "bpe_defs.vh"
module tb_backup_power_enable_ctrl;
  logic        clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0;
  logic        firstAlarmIrq = 1'b0, secondAlarmIrq = 1'b0, supplyOn;
  logic        regulatorWakeInput = 1'b0, waitrequest, irq;
  logic        regulatorWakeOutput, regulatorWakeOe;
  logic [7:0]  address = 8'h00, yearBcd = 8'h00;
  logic [31:0] writedata = 32'h0, readdata, q, seed = 32'h0000C61D;
  logic [31:0] mem [16];
  int          n_mismatch = 0, comparisons = 0;
  initial forever #25 clk = ~clk;
  bpe_ctrl u_dut (.clk, .rst_n, .ce(1'b1), .address, .read, .write,
    .writedata, .byteenable(4'hF), .readdata, .waitrequest, .firstAlarmIrq,
    .secondAlarmIrq, .yearBcd, .regulatorWakeInput, .regulatorWakeOutput,
    .regulatorWakeOe, .irq);
  bpe_pmic_model u_pmic (.clk, .enPin(regulatorWakeOutput),
    .oe(regulatorWakeOe), .pinLevel(), .supplyOn);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    // Request stands until waitrequest is sampled low at a rising edge
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      n_mismatch++;
      summarize();
    end else begin
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // Expected {irq, oe, out}
  task automatic pins(input logic [2:0] p);
    repeat (3) @(negedge clk);
    chk(32'({irq, regulatorWakeOe, regulatorWakeOutput}), 32'(p));
  endtask
  task automatic ev(input logic [2:0] e);
    @(posedge clk);
    yearBcd <= e[2] ? 8'h99 : 8'h42;
    @(posedge clk);
    yearBcd <= 8'h00;
    firstAlarmIrq <= e[0];
    secondAlarmIrq <= e[1];
    @(posedge clk);
    firstAlarmIrq <= 1'b0;
    secondAlarmIrq <= 1'b0;
  endtask
  task automatic rst();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  initial begin
    logic [2:0] m, e;
    rst();
    rdc(`BPE_OFS_CTL, 32'h00000F00);
    rdc(`BPE_OFS_STATUS, 32'h3);
    bus(1'b1, 8'h20, 32'hFFFFFFFF);
    rdc(8'h20, 32'h0);
    bus(1'b1, `BPE_OFS_CTL, 32'h100);
    rdc(`BPE_OFS_CTL, 32'hD00);
    bus(1'b1, `BPE_OFS_CTL, 32'hF3A);
    bus(1'b1, `BPE_OFS_CTL, 32'h33A);
    pins(3'b010);
    rdc(`BPE_OFS_STATUS, 32'h2);
    repeat (10) @(negedge clk);
    chk(32'(supplyOn), 32'h0);
    bus(1'b1, `BPE_OFS_CTL, 32'hB3A);
    pins(3'b011);
    bus(1'b1, `BPE_OFS_CTL, 32'h13A);
    pins(3'b000);
    bus(1'b1, `BPE_OFS_CTL, 32'h100);
    pins(3'b010);
    bus(1'b1, `BPE_OFS_CTL, 32'h33A);
    @(posedge clk) regulatorWakeInput <= 1'b1;
    @(posedge clk) regulatorWakeInput <= 1'b0;
    pins(3'b011);
    for (int k = 0; k < 12; k++) begin
      {e, m} = 6'(xs());
      if (k == 0) {e, m} = 6'h3F;
      bus(1'b1, `BPE_OFS_CTL, 32'h33A);
      bus(1'b1, `BPE_OFS_MASK, {29'h0, m});
      ev(e);
      pins({|(m & e), 1'b1, |(m & e)});
      rdc(`BPE_OFS_INTR, {29'h0, e});
      rdc(`BPE_OFS_MASKED, {29'h0, m & e});
      rdc(`BPE_OFS_MASK, {29'h0, m});
      bus(1'b1, `BPE_OFS_INTR, 32'h7);
      rdc(`BPE_OFS_INTR, 32'h0);
    end
    foreach (mem[k]) begin
      mem[k] = xs();
      bus(1'b1, 8'h40 + 8'(k * 4), mem[k]);
    end
    foreach (mem[k]) rdc(8'h40 + 8'(k * 4), mem[k]);
    bus(1'b1, `BPE_OFS_CTL, 32'h13A);
    bus(1'b1, `BPE_OFS_CTL, 32'h53A);
    pins(3'b011);
    rst();
    rdc(`BPE_OFS_CTL, 32'h00000F00);
    pins(3'b011);
    rdc(8'h40, mem[0]);
    summarize();
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
endmodule
